// *** design/pstsq_defines.svh ***
// Constants of the preflight self-test sequencer: timing, test ranges, offsets.
// Assumes a 200 MHz aclk; included by bare name.
`ifndef PSTSQ_DEFINES_SVH
`define PSTSQ_DEFINES_SVH

`define PSTSQ_CLK_MHZ      200
`define PSTSQ_HALF_NS      1000
`define PSTSQ_SETTLE_NS    200
`define PSTSQ_HALF_CYC     ((`PSTSQ_HALF_NS * `PSTSQ_CLK_MHZ + 999) / 1000)
`define PSTSQ_SETTLE_CYC   ((`PSTSQ_SETTLE_NS * `PSTSQ_CLK_MHZ + 999) / 1000)
`define PSTSQ_TIMER_W      16

`define PSTSQ_TNUM_W       7
`define PSTSQ_NUM_TESTS    7'h70
`define PSTSQ_FIRST_PITCH  7'h00
`define PSTSQ_LAST_PITCH   7'h27
`define PSTSQ_FIRST_ROLL   7'h28
`define PSTSQ_LAST_ROLL    7'h4f
`define PSTSQ_FIRST_YAW    7'h50
`define PSTSQ_LAST_YAW     7'h6f

// Monitoring points of one channel, second selector stage
`define PSTSQ_NUM_POINTS   16
`define PSTSQ_PT_PITCH_LE  4'h0
`define PSTSQ_PT_PITCH_RE  4'h1
`define PSTSQ_PT_ROLL_LE   4'h2
`define PSTSQ_PT_ROLL_RE   4'h3
`define PSTSQ_PT_PITCH_PE  4'h4
`define PSTSQ_PT_ROLL_PE   4'h5
`define PSTSQ_PT_YAW_PE    4'h6
`define PSTSQ_PT_PITCH_TR  4'h7
`define PSTSQ_PT_ROLL_TR   4'h8
`define PSTSQ_PT_YAW_TR    4'h9

// Register byte offsets
`define PSTSQ_ADDR_W       6
`define PSTSQ_CTRL_OFF     6'h00
`define PSTSQ_STAT_OFF     6'h04
`define PSTSQ_RES0_OFF     6'h08
`define PSTSQ_RES1_OFF     6'h0c
`define PSTSQ_RES2_OFF     6'h10
`define PSTSQ_ISTAT_OFF    6'h14
`define PSTSQ_IMASK_OFF    6'h18
`define PSTSQ_TADDR_OFF    6'h1c
`define PSTSQ_TDATA_OFF    6'h20

`define PSTSQ_IMASK_RST    6'h00
`define PSTSQ_RESP_OKAY    2'h0
`define PSTSQ_RESP_SLVERR  2'h2

`endif

// *** design/pstsq_pkg.sv ***
// Types of the preflight self-test sequencer.
// Assumes pstsq_defines.svh for widths.
`include "pstsq_defines.svh"

package pstsq_pkg;

  typedef enum logic [2:0] {
    PSTSQ_IDLE,
    PSTSQ_RESET_HALF,
    PSTSQ_STIM_HALF,
    PSTSQ_PASSED,
    PSTSQ_FAILED
  } pstsq_state_t;

  // One stored test; stim_n and keep_n are active low
  typedef struct packed {
    logic [2:0]  spare;
    logic        pre_engage_pred;
    logic [2:0]  chan_pred;
    logic [11:0] point_sel;
    logic [11:0] stim_n;
    logic        keep_n;
  } pstsq_entry_t;

  typedef struct packed {
    pstsq_state_t             state;
    logic [`PSTSQ_TNUM_W-1:0] tnum;
    logic [`PSTSQ_TIMER_W-1:0] timer;
    logic [3:0]               sel;
    logic [11:0]              stim;
    logic                     comp_reset;
    logic                     diag_valid;
    logic [1:0]               diag_code;
    logic [3:0]               diag_point;
    logic                     pass_evt;
    logic                     fail_evt;
  } pstsq_axis_regs_t;

  typedef struct packed {
    logic                     aw_got;
    logic [`PSTSQ_ADDR_W-1:0] awaddr;
    logic                     w_got;
    logic [31:0]              wdata;
    logic [3:0]               wstrb;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     rvalid;
    logic [31:0]              rdata;
    logic [1:0]               rresp;
    logic [2:0]               start;
    logic [5:0]               irq_stat;
    logic [5:0]               irq_mask;
    logic [`PSTSQ_TNUM_W-1:0] tbl_addr;
    logic                     irq;
  } pstsq_regs_t;

endpackage

// *** design/pstsq_axis_if.sv ***
// Carrier between the register block and one axis sequencer.
// Assumes one instance per axis, all on aclk.
`timescale 1ns/10ps
`include "pstsq_defines.svh"

interface pstsq_axis_if;
  import pstsq_pkg::*;
  logic                     start;
  pstsq_entry_t             entry;
  logic [2:0][15:0]         points;
  logic                     pre_engage;
  logic [`PSTSQ_TNUM_W-1:0] tnum;
  logic                     active;
  logic                     passed;
  logic                     comp_reset;
  logic [11:0]              stim_en;
  logic                     diag_valid;
  logic [1:0]               diag_code;
  logic [3:0]               diag_point;
  logic                     pass_evt;
  logic                     fail_evt;

  modport seq (input start, entry, points, pre_engage,
               output tnum, active, passed, comp_reset, stim_en, diag_valid, diag_code,
               diag_point, pass_evt, fail_evt);
  modport ctl (output start, entry, points, pre_engage,
               input tnum, active, passed, comp_reset, stim_en, diag_valid, diag_code,
               diag_point, pass_evt, fail_evt);
endinterface // pstsq_axis_if

// *** design/pstsq_axis.sv ***
// One axis test sequencer: test counter, half cycles, compare and failure latch.
// Assumes the stored entry for tnum arrives combinationally on the carrier.
`timescale 1ns/10ps
`include "pstsq_defines.svh"

module pstsq_axis
  import pstsq_pkg::*;
#(
  parameter logic [`PSTSQ_TNUM_W-1:0] FIRST = `PSTSQ_FIRST_PITCH,
  parameter logic [`PSTSQ_TNUM_W-1:0] LAST  = `PSTSQ_LAST_PITCH
) (
  input  wire logic  aclk,
  input  wire logic  aresetn,
  pstsq_axis_if.seq  bus
);

  localparam logic [`PSTSQ_TIMER_W-1:0] HALF_LAST  = `PSTSQ_TIMER_W'(`PSTSQ_HALF_CYC - 1);
  localparam logic [`PSTSQ_TIMER_W-1:0] SETTLE_CYC = `PSTSQ_TIMER_W'(`PSTSQ_SETTLE_CYC);

  pstsq_axis_regs_t r_reg, r_next;
  logic [3:0]       pred;
  logic [3:0]       miss;

  assign pred = {bus.entry.pre_engage_pred, bus.entry.chan_pred};
  assign miss = r_reg.sel ^ pred;

  always_comb begin
    r_next          = r_reg;
    r_next.pass_evt = 1'b0;
    r_next.fail_evt = 1'b0;
    unique case (r_reg.state)
      PSTSQ_IDLE, PSTSQ_PASSED, PSTSQ_FAILED: begin
        if (bus.start) begin
          r_next.state      = PSTSQ_RESET_HALF;
          r_next.tnum       = FIRST;
          r_next.timer      = '0;
          r_next.diag_valid = 1'b0;
        end
      end
      PSTSQ_RESET_HALF: begin
        r_next.comp_reset = bus.entry.keep_n;
        r_next.timer      = r_reg.timer + 1'b1;
        if (r_reg.timer == HALF_LAST) begin
          r_next.state      = PSTSQ_STIM_HALF;
          r_next.timer      = '0;
          r_next.comp_reset = 1'b0;
          r_next.stim       = ~bus.entry.stim_n;
        end
      end
      PSTSQ_STIM_HALF: begin
        r_next.timer = r_reg.timer + 1'b1;
        if (r_reg.timer >= SETTLE_CYC) begin
          r_next.sel = {bus.pre_engage,
                        bus.points[2][bus.entry.point_sel[11:8]],
                        bus.points[1][bus.entry.point_sel[7:4]],
                        bus.points[0][bus.entry.point_sel[3:0]]};
        end
        if (r_reg.timer == HALF_LAST) begin
          r_next.timer = '0;
          r_next.stim  = '0;
          if (|miss) begin
            r_next.state      = PSTSQ_FAILED;
            r_next.diag_valid = 1'b1;
            r_next.fail_evt   = 1'b1;
            if (miss[3]) begin
              r_next.diag_code  = 2'h0;
              r_next.diag_point = 4'h0;
            end else if (miss[0]) begin
              r_next.diag_code  = 2'h1;
              r_next.diag_point = bus.entry.point_sel[3:0];
            end else if (miss[1]) begin
              r_next.diag_code  = 2'h2;
              r_next.diag_point = bus.entry.point_sel[7:4];
            end else begin
              r_next.diag_code  = 2'h3;
              r_next.diag_point = bus.entry.point_sel[11:8];
            end
          end else if (r_reg.tnum == LAST) begin
            r_next.state    = PSTSQ_PASSED;
            r_next.pass_evt = 1'b1;
          end else begin
            r_next.state = PSTSQ_RESET_HALF;
            r_next.tnum  = r_reg.tnum + 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg       <= '0;
      r_reg.state <= PSTSQ_IDLE;
      r_reg.tnum  <= FIRST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign bus.tnum       = r_reg.tnum;
  assign bus.active     = (r_reg.state == PSTSQ_RESET_HALF) || (r_reg.state == PSTSQ_STIM_HALF);
  assign bus.passed     = (r_reg.state == PSTSQ_PASSED);
  assign bus.comp_reset = r_reg.comp_reset;
  assign bus.stim_en    = r_reg.stim;
  assign bus.diag_valid = r_reg.diag_valid;
  assign bus.diag_code  = r_reg.diag_code;
  assign bus.diag_point = r_reg.diag_point;
  assign bus.pass_evt   = r_reg.pass_evt;
  assign bus.fail_evt   = r_reg.fail_evt;

endmodule // pstsq_axis

// *** design/pstsq_top.sv ***
// Preflight self-test sequencer top: AXI4-Lite registers, test table, three axes.
// Assumes all inputs synchronous to aclk; panel and monitors outside.
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/10ps
`include "pstsq_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module pstsq_top
  import pstsq_pkg::*;
(
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  input  wire logic                            s_axi_awvalid,
  output wire logic                            s_axi_awready,
  input  wire logic [`PSTSQ_ADDR_W-1:0]        s_axi_awaddr,
  input  wire logic                            s_axi_wvalid,
  output wire logic                            s_axi_wready,
  input  wire logic [31:0]                     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  output wire logic                            s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  output wire logic [1:0]                      s_axi_bresp,
  input  wire logic                            s_axi_arvalid,
  output wire logic                            s_axi_arready,
  input  wire logic [`PSTSQ_ADDR_W-1:0]        s_axi_araddr,
  output wire logic                            s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  output wire logic [31:0]                     s_axi_rdata,
  output wire logic [1:0]                      s_axi_rresp,
  input  wire logic [2:0][2:0][15:0]           mon_points,
  input  wire logic [2:0]                      pre_engage_monitor,
  output wire logic [2:0]                      comp_reset,
  output wire logic [2:0][11:0]                stim_en,
  output wire logic [2:0]                      self_test_active,
  output wire logic [2:0][`PSTSQ_TNUM_W-1:0]   test_number,
  output wire logic [2:0]                      diag_valid,
  output wire logic [2:0][1:0]                 diag_code,
  output wire logic [2:0][3:0]                 diag_point,
  output wire logic                            irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  pstsq_regs_t          r_reg, r_next;
  logic [31:0]          tbl_mem [`PSTSQ_NUM_TESTS];
  logic [31:0]          strb_mask;
  logic                 wr_fire;
  logic                 rd_fire;
  logic                 tbl_we;
  logic [31:0]          tbl_wdata;
  logic [5:0]           irq_evt;
  logic [5:0]           irq_clr;
  logic [2:0]           ax_active;
  logic [2:0]           ax_passed;
  logic [2:0]           ax_dvalid;
  logic [2:0][31:0]     ax_result;

  pstsq_axis_if ax_if[3] ();

  ////////////////////////////////////////////////////////////////////////////////
  // Axis sequencers

  for (genvar g = 0; g < 3; g++) begin : g_axis
    localparam logic [`PSTSQ_TNUM_W-1:0] FIRST = (g == 0) ? `PSTSQ_FIRST_PITCH :
                                                 (g == 1) ? `PSTSQ_FIRST_ROLL :
                                                            `PSTSQ_FIRST_YAW;
    localparam logic [`PSTSQ_TNUM_W-1:0] LAST  = (g == 0) ? `PSTSQ_LAST_PITCH :
                                                 (g == 1) ? `PSTSQ_LAST_ROLL :
                                                            `PSTSQ_LAST_YAW;

    pstsq_axis #(
      .FIRST (FIRST),
      .LAST  (LAST)
    ) u_axis (
      .aclk    (aclk),
      .aresetn (aresetn),
      .bus     (ax_if[g])
    );

    assign ax_if[g].start  = r_reg.start[g];
    assign ax_if[g].entry  = pstsq_entry_t'(tbl_mem[ax_if[g].tnum]);
    assign ax_if[g].points = mon_points[g];
    assign ax_if[g].pre_engage = pre_engage_monitor[g];

    assign comp_reset[g]       = ax_if[g].comp_reset;
    assign stim_en[g]          = ax_if[g].stim_en;
    assign self_test_active[g] = ax_if[g].active;
    assign test_number[g]      = ax_if[g].tnum;
    assign diag_valid[g]       = ax_if[g].diag_valid;
    assign diag_code[g]        = ax_if[g].diag_code;
    assign diag_point[g]       = ax_if[g].diag_point;

    assign ax_active[g] = ax_if[g].active;
    assign ax_passed[g] = ax_if[g].passed;
    assign ax_dvalid[g] = ax_if[g].diag_valid;
    assign irq_evt[g]   = ax_if[g].pass_evt;
    assign irq_evt[g+3] = ax_if[g].fail_evt;
    assign ax_result[g] = {18'h00000, ax_if[g].diag_point, ax_if[g].diag_code,
                           ax_if[g].diag_valid, ax_if[g].tnum};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshakes

  assign s_axi_awready = !r_reg.aw_got && !r_reg.bvalid;
  assign s_axi_wready  = !r_reg.w_got && !r_reg.bvalid;
  assign s_axi_bvalid  = r_reg.bvalid;
  assign s_axi_bresp   = r_reg.bresp;
  assign s_axi_arready = !r_reg.rvalid;
  assign s_axi_rvalid  = r_reg.rvalid;
  assign s_axi_rdata   = r_reg.rdata;
  assign s_axi_rresp   = r_reg.rresp;
  assign irq           = r_reg.irq;

  assign wr_fire = r_reg.aw_got && r_reg.w_got && !r_reg.bvalid;
  assign rd_fire = s_axi_arvalid && !r_reg.rvalid;

  for (genvar b = 0; b < 4; b++) begin : g_strb
    assign strb_mask[8*b +: 8] = {8{r_reg.wstrb[b]}};
  end

  assign tbl_we    = wr_fire && (r_reg.awaddr == `PSTSQ_TDATA_OFF);
  assign tbl_wdata = (tbl_mem[r_reg.tbl_addr] & ~strb_mask) | (r_reg.wdata & strb_mask);
  assign irq_clr   = (rd_fire && (s_axi_araddr == `PSTSQ_ISTAT_OFF)) ? 6'h3f : 6'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Register logic

  always_comb begin
    r_next       = r_reg;
    r_next.start = 3'h0;

    if (s_axi_awvalid && s_axi_awready) begin
      r_next.aw_got = 1'b1;
      r_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      r_next.w_got = 1'b1;
      r_next.wdata = s_axi_wdata;
      r_next.wstrb = s_axi_wstrb;
    end

    if (wr_fire) begin
      r_next.aw_got = 1'b0;
      r_next.w_got  = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp  = `PSTSQ_RESP_OKAY;
      case (r_reg.awaddr)
        `PSTSQ_CTRL_OFF:  r_next.start = r_reg.wdata[2:0] & strb_mask[2:0];
        `PSTSQ_IMASK_OFF: r_next.irq_mask = (r_reg.irq_mask & ~strb_mask[5:0]) |
                                            (r_reg.wdata[5:0] & strb_mask[5:0]);
        `PSTSQ_TADDR_OFF: begin
          if (r_reg.wstrb[0]) begin
            r_next.tbl_addr = (r_reg.wdata[`PSTSQ_TNUM_W-1:0] < `PSTSQ_NUM_TESTS) ?
                              r_reg.wdata[`PSTSQ_TNUM_W-1:0] : '0;
          end
        end
        `PSTSQ_TDATA_OFF: begin
          r_next.tbl_addr = (r_reg.tbl_addr == `PSTSQ_NUM_TESTS - 7'h01) ? '0 :
                            r_reg.tbl_addr + 1'b1;
        end
        `PSTSQ_STAT_OFF, `PSTSQ_RES0_OFF, `PSTSQ_RES1_OFF, `PSTSQ_RES2_OFF,
        `PSTSQ_ISTAT_OFF: ;
        default:          r_next.bresp = `PSTSQ_RESP_SLVERR;
      endcase
    end
    if (r_reg.bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end

    if (rd_fire) begin
      r_next.rvalid = 1'b1;
      r_next.rresp  = `PSTSQ_RESP_OKAY;
      case (s_axi_araddr)
        `PSTSQ_CTRL_OFF:  r_next.rdata = 32'h0000_0000;
        `PSTSQ_STAT_OFF:  r_next.rdata = {23'h000000, ax_dvalid, ax_passed, ax_active};
        `PSTSQ_RES0_OFF:  r_next.rdata = ax_result[0];
        `PSTSQ_RES1_OFF:  r_next.rdata = ax_result[1];
        `PSTSQ_RES2_OFF:  r_next.rdata = ax_result[2];
        `PSTSQ_ISTAT_OFF: r_next.rdata = {26'h0000000, r_reg.irq_stat};
        `PSTSQ_IMASK_OFF: r_next.rdata = {26'h0000000, r_reg.irq_mask};
        `PSTSQ_TADDR_OFF: r_next.rdata = {25'h0000000, r_reg.tbl_addr};
        `PSTSQ_TDATA_OFF: r_next.rdata = tbl_mem[r_reg.tbl_addr];
        default: begin
          r_next.rdata = 32'h0000_0000;
          r_next.rresp = `PSTSQ_RESP_SLVERR;
        end
      endcase
    end else if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end

    // A new event beats a clear-on-read in the same cycle
    r_next.irq_stat = (r_reg.irq_stat & ~irq_clr) | irq_evt;
    r_next.irq      = |(r_next.irq_stat & r_next.irq_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg          <= '0;
      r_reg.irq_mask <= `PSTSQ_IMASK_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // Test table; contents loaded by software before a run
  always_ff @(posedge aclk) begin
    if (tbl_we) begin
      tbl_mem[r_reg.tbl_addr] <= tbl_wdata;
    end
  end

endmodule // pstsq_top

// *** verification/pstsq_monitor.sv ***
// Checker on the self-test sequencer top ports.
// Assumes one aclk domain; bound into pstsq_top at the foot.
`timescale 1ns/10ps
`include "pstsq_defines.svh"

module pstsq_monitor
  import pstsq_pkg::*;
(
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic [2:0]            comp_reset,
  input wire logic [2:0][11:0]      stim_en,
  input wire logic [2:0]            self_test_active,
  input wire logic [2:0][`PSTSQ_TNUM_W-1:0] test_number,
  input wire logic [2:0]            diag_valid,
  input wire logic [2:0][1:0]       diag_code
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_fail_halts_run: assert property ((diag_valid & self_test_active) == 3'h0)
    else $error("diag lit while active");
  a_halt_holds_number: assert property (diag_valid[1] && $past(diag_valid[1])
    |-> $stable(test_number[1])) else $error("halted number moved");
  a_pitch_range: assert property (self_test_active[0] |-> test_number[0] <= 7'h27)
    else $error("pitch number out of range");
  a_step_one: assert property (self_test_active[0] && $past(self_test_active[0])
    && $changed(test_number[0]) |-> test_number[0] == $past(test_number[0]) + 7'h01)
    else $error("counter skipped");
  a_stim_span: assert property ($rose(stim_en[0] != 12'h000) |-> ##199
    (stim_en[0] != 12'h000) ##1 (stim_en[0] == 12'h000)) else $error("stim span");
  a_reset_no_stim: assert property (comp_reset[0] |-> stim_en[0] == 12'h000)
    else $error("reset and stim overlap");
  a_reset_state: assert property ($rose(aresetn) |-> diag_valid == 3'h0
    && test_number == {7'h50, 7'h28, 7'h00}) else $error("reset values");
  a_start_first: assert property ($rose(self_test_active[1]) |->
    test_number[1] == 7'h28 && !diag_valid[1]) else $error("start not at first");

  c_roll_fail: cover property ($rose(diag_valid[1]) && diag_code[1] == 2'h2);
  c_yaw_pre_engage: cover property ($rose(diag_valid[2]) && diag_code[2] == 2'h0);
  c_pitch_pass: cover property ($fell(self_test_active[0]) && !diag_valid[0]);
endmodule // pstsq_monitor

bind pstsq_top pstsq_monitor u_mon (.aclk, .aresetn, .comp_reset, .stim_en,
  .self_test_active, .test_number, .diag_valid, .diag_code);

// *** verification/pstsq_mon_model.sv ***
// Comparator monitors: each applied stimulus trips its point until reset.
// Assumes stim_en bit c*4+k drives point k of channel c.
`timescale 1ns/10ps

module pstsq_mon_model
  import pstsq_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [2:0]       comp_reset,
  input  wire logic [2:0][11:0] stim_en,
  output logic [2:0][2:0][15:0] mon_points,
  output logic [2:0]            pre_engage_monitor
);
  logic [2:0][11:0] trip_reg;

  always_ff @(posedge aclk) begin
    for (int a = 0; a < 3; a++) begin
      if (!aresetn || comp_reset[a]) trip_reg[a] <= 12'h000;
      else trip_reg[a] <= trip_reg[a] | stim_en[a];
    end
  end

  always_comb begin
    for (int a = 0; a < 3; a++) begin
      pre_engage_monitor[a] = |trip_reg[a];
      for (int c = 0; c < 3; c++) mon_points[a][c] = {12'h000, trip_reg[a][c*4+:4]};
    end
  end
endmodule // pstsq_mon_model

// *** verification/tb_preflight_self_test_sequencer.sv ***
// Bench: loads a random test table over AXI4-Lite, runs the axes, checks results.
// Assumes the design, its package, the monitor model and checker are compiled first.
`timescale 1ns/10ps
`include "pstsq_defines.svh"

module tb_preflight_self_test_sequencer;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [2:0][2:0][15:0] mon_points;
  wire logic [2:0] pre_engage_monitor, comp_reset, self_test_active, diag_valid;
  wire logic [2:0][11:0] stim_en;
  wire logic [2:0][6:0] test_number;
  wire logic [2:0][1:0] diag_code;
  wire logic [2:0][3:0] diag_point;
  int n_fail = 0, n_tests = 0, cyc = 0;
  logic [31:0] seed = 32'h71b4, q, tbl [112];
  logic [1:0] r;

  pstsq_top dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .mon_points, .pre_engage_monitor,
    .comp_reset, .stim_en, .self_test_active, .test_number, .diag_valid, .diag_code,
    .diag_point, .irq);
  pstsq_mon_model u_model (.aclk, .aresetn, .comp_reset, .stim_en, .mon_points,
    .pre_engage_monitor);

  initial forever #2.5 aclk = ~aclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task test_done;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
    logic ah, dh, rh;
    @(posedge aclk);
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    rh = 1'b0;
    while (rh !== 1'b1) begin
      @(negedge aclk);
      ah = w ? s_axi_awvalid & s_axi_awready : s_axi_arvalid & s_axi_arready;
      dh = s_axi_wvalid & s_axi_wready;
      rh = w ? s_axi_bvalid & s_axi_bready : s_axi_rvalid & s_axi_rready;
      q = s_axi_rdata;
      r = w ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (ah === 1'b1 && w) s_axi_awvalid <= 1'b0;
      if (ah === 1'b1 && !w) s_axi_arvalid <= 1'b0;
      if (dh === 1'b1) s_axi_wvalid <= 1'b0;
      if (rh === 1'b1) s_axi_bready <= 1'b0;
      if (rh === 1'b1) s_axi_rready <= 1'b0;
    end
  endtask

  task wr(input logic [5:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rd(input logic [5:0] a);
    xfer(1'b0, a, 32'h0);
  endtask

  // Mirror of the trip state gives each entry's predictions
  task build;
    logic [3:0] st [3][3];
    logic [11:0] sn;
    logic [2:0] pr;
    int a;
    for (int t = 0; t < 112; t++) begin
      a = t < 40 ? 0 : (t < 80 ? 1 : 2);
      seed = lfsr(seed);
      sn = seed[11:0] | seed[23:12];
      for (int c = 0; c < 3; c++) begin
        if (t % 5 != 3) st[a][c] = 4'h0;
        st[a][c] = st[a][c] | ~sn[c*4+:4];
        pr[c] = st[a][c][seed[24+2*c+:2]];
      end
      tbl[t] = {3'h0, |{st[a][0], st[a][1], st[a][2]}, pr, 2'h0, seed[29:28], 2'h0,
        seed[27:26], 2'h0, seed[25:24], sn, t % 5 != 3};
    end
    tbl[45] = tbl[45] ^ 32'h0400_0000;
    tbl[85] = tbl[85] ^ 32'h1200_0000;
  endtask

  task wait_idle;
    @(negedge aclk);
    while (self_test_active !== 3'h0) @(negedge aclk);
  endtask

  ////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      test_done;
    end
  end

  initial begin
    build;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(test_number, {7'h50, 7'h28, 7'h00});
    chk({irq, self_test_active, diag_valid}, 32'h0);
    rd(6'h18);
    chk(q, 32'h0);
    rd(6'h24);
    chk(q, 32'h0);
    chk(r, 2'h2);
    wr(6'h24, 32'hffff_ffff);
    chk(r, 2'h2);
    wr(6'h04, 32'hffff_ffff);
    rd(6'h04);
    chk(q, 32'h0);
    wr(6'h1c, 32'h0);
    for (int t = 0; t < 112; t++) wr(6'h20, tbl[t]);
    wr(6'h1c, 32'h7f);
    rd(6'h1c);
    chk(q, 32'h0);
    wr(6'h1c, 32'h2d);
    rd(6'h20);
    chk(q, tbl[45]);
    // Byte lane 0 masked off: the mask write must not land
    s_axi_wstrb <= 4'he;
    wr(6'h18, 32'h3f);
    s_axi_wstrb <= 4'hf;
    rd(6'h18);
    chk(q, 32'h0);
    wr(6'h18, 32'h3f);
    rd(6'h18);
    chk(q, 32'h3f);
    wr(6'h00, 32'h4);
    @(negedge aclk);
    chk(self_test_active, 3'h4);
    wr(6'h00, 32'h3);
    @(negedge aclk);
    chk(self_test_active, 3'h7);
    wait_idle;
    rd(6'h04);
    chk(q, 32'h188);
    rd(6'h0c);
    chk(q, {tbl[45][20:17], 2'h2, 1'b1, 7'h2d});
    rd(6'h10);
    chk(q, {4'h0, 2'h0, 1'b1, 7'h55});
    chk({diag_code[1], diag_point[1]}, {2'h2, tbl[45][20:17]});
    chk(irq, 1'b1);
    rd(6'h14);
    chk(q, 32'h31);
    repeat (3) @(negedge aclk);
    chk(irq, 1'b0);
    wr(6'h18, 32'h0);
    wr(6'h00, 32'h2);
    @(negedge aclk);
    chk({diag_valid[1], test_number[1]}, {1'b0, 7'h28});
    wait_idle;
    chk({irq, test_number[1]}, {1'b0, 7'h2d});
    wr(6'h18, 32'h10);
    repeat (3) @(negedge aclk);
    chk(irq, 1'b1);
    rd(6'h14);
    chk(q, 32'h10);
    test_done;
  end
endmodule // tb_preflight_self_test_sequencer
